// ==== logic/cerad_datapath.sv ====
// Register file, fixed-point unit, decimal sign unit and storage map
// Operation
// RULE1: Sixteen general registers 0-15 chosen by a four-bit select field.
// RULE2: Each general register is one 32-bit word for index and accumulation.
// RULE3: Pair ops need an even register; next register holds low half.
// RULE4: Four 64-bit floating registers, reached only as numbers 0,2,4,6.
// RULE5: Short float uses upper word; lower word is left unchanged.
// RULE6: Opcode alone picks general or floating register set.
// RULE7: Fixed point works on 32-bit words and accepts 16-bit halfwords.
// RULE8: Dividends and wide products are 64 bits in an even/odd pair.
// RULE9: Arithmetic takes one register operand, second from register or storage.
// RULE10: Twos complement values; carry out of the word is reported.
// RULE11: Shifter moves one register or a pair, left or right.
// RULE12: Decimal work is storage to storage, add to compare, no registers.
// RULE13: Decimal operands are sign-magnitude fields of one to sixteen bytes.
// RULE14: Codes 0-9 are digits; codes A-F are signs only.
// RULE15: Sign codes B and D read negative, other four positive.
// RULE16: Generated signs follow the mode bit: C/D or A/B.
// RULE17: Packed fields hold two digits a byte, sign in last low nibble.
// RULE18: Decimal fields start anywhere and may differ in length.
// RULE19: Zoned sign in last high nibble; decimal arithmetic refuses zoned.
// RULE20: Main storage from address 0; display storage from 2,621,440 with gaps.
// RULE21: Display access never wraps past its module end.
// RULE22: Storage addresses are 24-bit values.
// RULE23: Bad digit code raises a data exception instead of a result.
`timescale 1ns/1ns
module cerad_datapath (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [3:0] r1_sel,
  input wire logic [3:0] r2_sel,
  input wire logic src_storage,
  input wire logic halfword,
  input wire logic [5:0] shift_amt,
  // Storage operand
  input wire logic [31:0] stor_operand,
  input wire logic [63:0] fp_operand,
  // Address generation
  input wire logic [23:0] addr_disp,
  input wire logic [5:0] access_len,
  // Decimal byte stream
  input wire logic dec_valid,
  input wire logic [7:0] dec_byte,
  input wire logic dec_last,
  input wire logic dec_zoned,
  input wire logic [4:0] dec_len,
  input wire logic program_status_word_ext,
  // Results
  output logic op_done,
  output logic spec_error,
  output logic [31:0] result_q,
  output logic carry_q,
  output logic [1:0] cond_q,
  output logic [63:0] fp_view_q,
  // Storage address
  output logic [23:0] stor_addr_q,
  output logic main_sel_q,
  output logic display_sel_q,
  output logic addr_error_q,
  // Decimal status
  output logic data_exception_q,
  output logic dec_neg_q,
  output logic [3:0] sign_plus_q,
  output logic [3:0] sign_minus_q
);
  cerad_dec_if dec_link ();
  cerad_pkg::cerad_state_t state_q, state_d;
  logic [31:0] gpr_q [cerad_pkg::GPR_COUNT];
  logic [63:0] fpr_q [cerad_pkg::FPR_COUNT];
  cerad_pkg::cerad_op_t op;
  logic is_fp_op, is_pair_op, odd_pair, bad_fpr, bad_dec;
  logic [3:0] r1_lo;
  logic [31:0] op1, op2, op2_ext;
  logic [63:0] pair1, shl64, shr64, prod64;
  logic [32:0] sum33, dif33;
  logic [31:0] alu_res;
  logic alu_carry, wr_r1, wr_pair;
  logic [31:0] wr_hi, wr_lo;
  logic [1:0] fidx;
  logic [31:0] quo, rem;
  logic div_zero;
  logic [23:0] disp_off, mod_off;
  logic [2:0] mod_idx;
  logic in_main, in_disp, over_mod;
  logic [24:0] end_addr;
  logic signed [63:0] mul_a, mul_b;
  logic cmp_lt;
  logic [1:0] cmp_cond, res_cond, cond_d;

  // RULE6 opcode picks set
  assign is_fp_op = (op == cerad_pkg::CERAD_OP_FLD_S) || (op == cerad_pkg::CERAD_OP_FLD_L);
  assign op = cerad_pkg::cerad_op_t'(op_code);
  // RULE3 even pair check
  // RULE8 pair operations
  assign is_pair_op = (op == cerad_pkg::CERAD_OP_MUL) || (op == cerad_pkg::CERAD_OP_DIV) ||
    (op == cerad_pkg::CERAD_OP_SLDL) || (op == cerad_pkg::CERAD_OP_SRDL);
  assign odd_pair = is_pair_op && r1_sel[0];
  assign r1_lo = {r1_sel[3:1], 1'b1};
  // RULE4 floating numbers even
  assign bad_fpr = is_fp_op && (r1_sel[0] || (r1_sel > 4'h6));
  assign fidx = r1_sel[2:1];
  // RULE19 zoned refused
  // RULE13 length one to sixteen
  assign bad_dec = (op == cerad_pkg::CERAD_OP_DEC) &&
    (dec_zoned || (dec_len == 5'h00) || (dec_len > 5'(cerad_pkg::DEC_MAX_BYTES)));
  assign spec_error = op_valid && (odd_pair || bad_fpr || bad_dec);

  // RULE1 four-bit select
  // RULE2 word operands
  // RULE9 second operand source
  // RULE7 halfword sign extend
  assign op1 = gpr_q[r1_sel];
  assign op2 = src_storage ? stor_operand : gpr_q[r2_sel];
  assign op2_ext = halfword ? {{16{op2[15]}}, op2[15:0]} : op2;
  assign pair1 = {op1, gpr_q[r1_lo]};

  // RULE10 twos complement carry
  assign sum33 = {1'b0, op1} + {1'b0, op2_ext};
  assign dif33 = {1'b0, op1} + {1'b0, ~op2_ext} + 33'h000000001;
  // RULE8 wide product
  // Factors widened with sign first, no product bits lost
  assign mul_a = 64'($signed(gpr_q[r1_lo]));
  assign mul_b = 64'($signed(op2_ext));
  assign prod64 = mul_a * mul_b;
  // RULE11 single and pair shift
  assign shl64 = pair1 << shift_amt;
  assign shr64 = pair1 >> shift_amt;
  assign div_zero = (op2_ext == 32'h00000000);
  assign quo = div_zero ? 32'h00000000 : 32'($signed(pair1) / $signed(op2_ext));
  assign rem = div_zero ? 32'h00000000 : 32'($signed(pair1) % $signed(op2_ext));

  // Fixed-point result selection
  always_comb begin
    alu_res = 32'h00000000;
    alu_carry = 1'b0;
    wr_r1 = 1'b0;
    wr_pair = 1'b0;
    wr_hi = 32'h00000000;
    wr_lo = 32'h00000000;
    case (op)
      cerad_pkg::CERAD_OP_ADD: begin
        alu_res = sum33[31:0];
        alu_carry = sum33[32];
        wr_r1 = 1'b1;
      end
      cerad_pkg::CERAD_OP_SUB: begin
        alu_res = dif33[31:0];
        alu_carry = dif33[32];
        wr_r1 = 1'b1;
      end
      cerad_pkg::CERAD_OP_CMP: begin
        alu_res = dif33[31:0];
        alu_carry = dif33[32];
      end
      cerad_pkg::CERAD_OP_MUL: begin
        wr_pair = 1'b1;
        wr_hi = prod64[63:32];
        wr_lo = prod64[31:0];
        alu_res = prod64[31:0];
      end
      cerad_pkg::CERAD_OP_DIV: begin
        wr_pair = !div_zero;
        wr_hi = rem;
        wr_lo = quo;
        alu_res = quo;
      end
      cerad_pkg::CERAD_OP_SLL: begin
        alu_res = (shift_amt[5]) ? 32'h00000000 : (op1 << shift_amt[4:0]);
        wr_r1 = 1'b1;
      end
      cerad_pkg::CERAD_OP_SRL: begin
        alu_res = (shift_amt[5]) ? 32'h00000000 : (op1 >> shift_amt[4:0]);
        wr_r1 = 1'b1;
      end
      cerad_pkg::CERAD_OP_SLDL: begin
        wr_pair = 1'b1;
        wr_hi = shl64[63:32];
        wr_lo = shl64[31:0];
        alu_res = shl64[63:32];
      end
      cerad_pkg::CERAD_OP_SRDL: begin
        wr_pair = 1'b1;
        wr_hi = shr64[63:32];
        wr_lo = shr64[31:0];
        alu_res = shr64[63:32];
      end
      cerad_pkg::CERAD_OP_LOAD: begin
        alu_res = op2_ext;
        wr_r1 = 1'b1;
      end
      default: begin
        alu_res = 32'h00000000;
      end
    endcase
  end

  // RULE9 signed compare
  // Signed order, immune to a wrapped difference
  assign cmp_lt = $signed(op1) < $signed(op2_ext);
  assign cmp_cond = (op1 == op2_ext) ? 2'b00 : (cmp_lt ? 2'b01 : 2'b10);
  // Other operations report zero, negative or positive
  assign res_cond = (alu_res == 32'h00000000) ? 2'b00 : (alu_res[31] ? 2'b01 : 2'b10);
  assign cond_d = (op == cerad_pkg::CERAD_OP_CMP) ? cmp_cond : res_cond;

  // Sequencer: divide takes two extra cycles
  always_comb begin
    state_d = state_q;
    case (state_q)
      cerad_pkg::CERAD_ST_IDLE: begin
        if (op_valid && !spec_error && (op == cerad_pkg::CERAD_OP_DIV)) begin
          state_d = cerad_pkg::CERAD_ST_DIV;
        end
      end
      cerad_pkg::CERAD_ST_DIV: state_d = cerad_pkg::CERAD_ST_DONE;
      cerad_pkg::CERAD_ST_DONE: state_d = cerad_pkg::CERAD_ST_IDLE;
      default: state_d = cerad_pkg::CERAD_ST_IDLE;
    endcase
  end
  assign op_done = (state_q == cerad_pkg::CERAD_ST_DONE) ||
    (op_valid && (state_q == cerad_pkg::CERAD_ST_IDLE) &&
    (spec_error || (op != cerad_pkg::CERAD_OP_DIV)));

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= cerad_pkg::CERAD_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // General register file, one entry per register
  genvar gi;
  generate
    for (gi = 0; gi < cerad_pkg::GPR_COUNT; gi++) begin : g_gpr
      logic take;
      assign take = op_valid && !spec_error && (state_q == cerad_pkg::CERAD_ST_IDLE);
      always_ff @(posedge clk) begin
        if (reset) begin
          gpr_q[gi] <= cerad_pkg::GPR_RESET;
        end else if (take && wr_r1 && (r1_sel == 4'(gi))) begin
          gpr_q[gi] <= alu_res;
        end else if (take && wr_pair && (r1_sel == 4'(gi))) begin
          gpr_q[gi] <= wr_hi;
        end else if (take && wr_pair && (r1_lo == 4'(gi))) begin
          gpr_q[gi] <= wr_lo;
        end
      end
    end
  endgenerate

  // Floating register file
  genvar fi;
  generate
    for (fi = 0; fi < cerad_pkg::FPR_COUNT; fi++) begin : g_fpr
      logic hit;
      assign hit = op_valid && !spec_error && (state_q == cerad_pkg::CERAD_ST_IDLE) &&
        (fidx == 2'(fi));
      always_ff @(posedge clk) begin
        if (reset) begin
          fpr_q[fi] <= cerad_pkg::FPR_RESET;
        end else if (hit && (op == cerad_pkg::CERAD_OP_FLD_L)) begin
          fpr_q[fi] <= fp_operand;
        end else if (hit && (op == cerad_pkg::CERAD_OP_FLD_S)) begin
          // RULE5 upper word only
          fpr_q[fi] <= {fp_operand[63:32], fpr_q[fi][31:0]};
        end
      end
    end
  endgenerate

  // Result and condition registers
  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= 32'h00000000;
      carry_q <= 1'b0;
      cond_q <= 2'b00;
      fp_view_q <= 64'h0000000000000000;
    end else if (op_valid && !spec_error && (state_q == cerad_pkg::CERAD_ST_IDLE)) begin
      result_q <= alu_res;
      carry_q <= alu_carry;
      cond_q <= cond_d;
      fp_view_q <= fpr_q[fidx];
    end
  end

  // RULE22 24-bit addressing
  // RULE20 storage map
  assign in_main = (addr_disp < cerad_pkg::DISPLAY_BASE);
  assign disp_off = addr_disp - cerad_pkg::DISPLAY_BASE;
  assign mod_idx = disp_off[21:19];
  assign mod_off = {5'h00, disp_off[18:0]};
  // Offsets past the last module stride are unmapped
  assign in_disp = !in_main && (disp_off[23:22] == 2'b00) &&
    (mod_idx < cerad_pkg::DISPLAY_MAX_MODS) &&
    (mod_off < cerad_pkg::DISPLAY_MOD_SIZE);
  // RULE21 no display wrap
  assign end_addr = {1'b0, mod_off} + 25'(access_len);
  assign over_mod = in_disp && (end_addr > {1'b0, cerad_pkg::DISPLAY_MOD_SIZE});

  always_ff @(posedge clk) begin
    if (reset) begin
      stor_addr_q <= cerad_pkg::MAIN_BASE;
      main_sel_q <= 1'b0;
      display_sel_q <= 1'b0;
      addr_error_q <= 1'b0;
    end else begin
      stor_addr_q <= addr_disp;
      main_sel_q <= in_main;
      display_sel_q <= in_disp && !over_mod;
      addr_error_q <= (!in_main && !in_disp) || over_mod;
    end
  end

  // RULE12 storage-only decimal
  // RULE18 any alignment
  assign dec_link.data_byte = dec_byte;
  assign dec_link.last_byte = dec_last;
  assign dec_link.zoned = dec_zoned;
  assign dec_link.ext_mode = program_status_word_ext;

  cerad_dec_check u_dec (
    .dec (dec_link)
  );

  // Decimal status registers
  always_ff @(posedge clk) begin
    if (reset) begin
      data_exception_q <= 1'b0;
      dec_neg_q <= 1'b0;
      sign_plus_q <= cerad_pkg::EXT_PLUS;
      sign_minus_q <= cerad_pkg::EXT_MINUS;
    end else begin
      sign_plus_q <= dec_link.gen_plus;
      sign_minus_q <= dec_link.gen_minus;
      // RULE23 data exception
      if (dec_valid) begin
        data_exception_q <= dec_link.digit_bad || dec_link.sign_bad || dec_zoned;
        dec_neg_q <= dec_link.neg;
      end
    end
  end
endmodule // cerad_datapath

// ==== logic/cerad_dec_check.sv ====
// Decimal byte checker: digit validity, sign reading and sign generation
`timescale 1ns/1ns
module cerad_dec_check (
  // Decimal byte link
  cerad_dec_if.chk dec
);
  logic [3:0] hi_nib;
  logic [3:0] lo_nib;
  logic [3:0] sign_nib;
  logic hi_is_sign;
  logic lo_is_sign;
  assign hi_nib = dec.data_byte[7:4];
  assign lo_nib = dec.data_byte[3:0];
  // RULE17 packed sign low
  // RULE19 zoned sign high
  assign hi_is_sign = dec.last_byte && dec.zoned;
  assign lo_is_sign = dec.last_byte && !dec.zoned;
  assign sign_nib = dec.zoned ? hi_nib : lo_nib;
  // RULE14 digit codes only
  // RULE23 flag bad digit
  assign dec.digit_bad = (!hi_is_sign && !dec.zoned && (hi_nib > cerad_pkg::DIGIT_MAX)) ||
    (!lo_is_sign && (lo_nib > cerad_pkg::DIGIT_MAX));
  assign dec.sign_bad = dec.last_byte && (sign_nib <= cerad_pkg::DIGIT_MAX);
  // RULE15 minus codes
  assign dec.neg = dec.last_byte &&
    ((sign_nib == cerad_pkg::SIGN_MINUS_A) || (sign_nib == cerad_pkg::SIGN_MINUS_B));
  // RULE16 generated signs
  assign dec.gen_plus = dec.ext_mode ? cerad_pkg::EXT_PLUS : cerad_pkg::ASC_PLUS;
  assign dec.gen_minus = dec.ext_mode ? cerad_pkg::EXT_MINUS : cerad_pkg::ASC_MINUS;
endmodule // cerad_dec_check

// ==== logic/cerad_dec_if.sv ====
// Interface carrying one decimal byte between the datapath and its checker
`timescale 1ns/1ns
interface cerad_dec_if;
  logic [7:0] data_byte;
  logic last_byte;
  logic zoned;
  logic ext_mode;
  logic neg;
  logic digit_bad;
  logic sign_bad;
  logic [3:0] gen_plus;
  logic [3:0] gen_minus;
  modport src (output data_byte, last_byte, zoned, ext_mode,
    input neg, digit_bad, sign_bad, gen_plus, gen_minus);
  modport chk (input data_byte, last_byte, zoned, ext_mode,
    output neg, digit_bad, sign_bad, gen_plus, gen_minus);
endinterface

// ==== logic/cerad_pkg.sv ====
// Package of constants and types for the register and arithmetic datapath
package cerad_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned DWORD_W = 64;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned GPR_COUNT = 16;
  localparam int unsigned FPR_COUNT = 4;
  localparam int unsigned DEC_MAX_BYTES = 16;
  localparam int unsigned DEC_MAX_DIGITS = 31;
  localparam int unsigned LEN_W = 4;
  localparam logic [31:0] GPR_RESET = 32'h00000000;
  localparam logic [63:0] FPR_RESET = 64'h0000000000000000;
  // Storage map
  localparam logic [23:0] MAIN_BASE = 24'h000000;
  localparam logic [23:0] DISPLAY_BASE = 24'h280000;
  localparam logic [23:0] DISPLAY_MOD_SIZE = 24'h040000;
  localparam logic [23:0] DISPLAY_STRIDE = 24'h080000;
  localparam logic [2:0] DISPLAY_MAX_MODS = 3'h5;
  // Sign codes
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] SIGN_MINUS_A = 4'hB;
  localparam logic [3:0] SIGN_MINUS_B = 4'hD;
  localparam logic [3:0] EXT_PLUS = 4'hC;
  localparam logic [3:0] EXT_MINUS = 4'hD;
  localparam logic [3:0] ASC_PLUS = 4'hA;
  localparam logic [3:0] ASC_MINUS = 4'hB;

  typedef enum logic [3:0] {
    CERAD_OP_NOP = 4'h0,
    CERAD_OP_ADD = 4'h1,
    CERAD_OP_SUB = 4'h2,
    CERAD_OP_MUL = 4'h3,
    CERAD_OP_DIV = 4'h4,
    CERAD_OP_CMP = 4'h5,
    CERAD_OP_SLL = 4'h6,
    CERAD_OP_SRL = 4'h7,
    CERAD_OP_SLDL = 4'h8,
    CERAD_OP_SRDL = 4'h9,
    CERAD_OP_LOAD = 4'hA,
    CERAD_OP_FLD_S = 4'hB,
    CERAD_OP_FLD_L = 4'hC,
    CERAD_OP_DEC = 4'hD
  } cerad_op_t;

  typedef enum logic [1:0] {
    CERAD_ST_IDLE = 2'b00,
    CERAD_ST_DIV = 2'b01,
    CERAD_ST_DONE = 2'b10
  } cerad_state_t;
endpackage

// ==== testbench/cerad_dp_props.sv ====
// Port-level assertions for the register and arithmetic datapath
`timescale 1ns/1ns
module cerad_dp_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Operation and address inputs
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [3:0] r1_sel,
  input wire logic [23:0] addr_disp,
  input wire logic [5:0] access_len,
  // Decimal inputs
  input wire logic dec_valid,
  input wire logic [7:0] dec_byte,
  input wire logic dec_last,
  input wire logic dec_zoned,
  input wire logic program_status_word_ext,
  // Watched outputs
  input wire logic spec_error,
  input wire logic main_sel_q,
  input wire logic display_sel_q,
  input wire logic addr_error_q,
  input wire logic data_exception_q,
  input wire logic dec_neg_q,
  input wire logic [3:0] sign_plus_q,
  input wire logic [3:0] sign_minus_q
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Offset of the access end inside a display module
  wire logic [18:0] mod_end;
  wire logic in_disp;
  assign mod_end = {1'b0, addr_disp[17:0]} + 19'(access_len);
  assign in_disp = addr_disp[23:18] inside {6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
  // Last packed byte with a good digit and a minus code
  sequence neg_last;
    dec_valid && dec_last && !dec_zoned && dec_byte[7:4] <= 4'h9
      && dec_byte[3:0] inside {4'hB, 4'hD};
  endsequence
  AST_SIGN_EXT: assert property (
    program_status_word_ext |=> sign_plus_q == 4'hC && sign_minus_q == 4'hD)
    else $error("extended mode sign codes wrong");
  AST_SIGN_ASC: assert property (
    !program_status_word_ext |=> sign_plus_q == 4'hA && sign_minus_q == 4'hB)
    else $error("ascii mode sign codes wrong");
  AST_MAIN_SEL: assert property (
    addr_disp < 24'h280000 && access_len != 6'h0 |=> main_sel_q && !display_sel_q)
    else $error("main storage not selected");
  AST_DISP_SEL: assert property (
    in_disp && access_len != 6'h0 && mod_end <= 19'h40000
      |=> display_sel_q && !main_sel_q && !addr_error_q)
    else $error("display storage not selected");
  AST_DISP_WRAP: assert property (
    in_disp && mod_end > 19'h40000 |=> addr_error_q)
    else $error("display access crossed module end");
  AST_GAP_ERR: assert property (
    addr_disp >= 24'h280000 && !in_disp |=> addr_error_q && !display_sel_q && !main_sel_q)
    else $error("unmapped address not refused");
  AST_PAIR_ODD: assert property (
    op_valid && op_code inside {4'h3, 4'h4, 4'h8, 4'h9} && r1_sel[0] |-> spec_error)
    else $error("odd pair register accepted");
  AST_NEG_SIGN: assert property (
    neg_last |=> dec_neg_q && !data_exception_q)
    else $error("minus sign not recognised");
  AST_BAD_DIGIT: assert property (
    dec_valid && !dec_last && dec_byte[7:4] > 4'h9 |=> data_exception_q)
    else $error("bad digit not flagged");
endmodule // cerad_dp_props

bind cerad_datapath cerad_dp_props u_props (
  .clk, .reset, .op_valid, .op_code, .r1_sel, .addr_disp, .access_len, .dec_valid,
  .dec_byte, .dec_last, .dec_zoned, .program_status_word_ext, .spec_error, .main_sel_q,
  .display_sel_q, .addr_error_q, .data_exception_q, .dec_neg_q, .sign_plus_q, .sign_minus_q
);

// ==== testbench/cerad_stor_model.sv ====
// Storage model answering word reads at the mapped address
`timescale 1ns/1ns
module cerad_stor_model (
  // Clock
  input wire logic clk,
  // Mapped address
  input wire logic [23:0] stor_addr_q,
  input wire logic main_sel_q,
  input wire logic display_sel_q,
  input wire logic addr_error_q,
  // Read word
  output logic [31:0] rd_word
);
  logic [31:0] last_q = 32'h00000000;
  wire logic hit;
  assign hit = (main_sel_q | display_sel_q) & ~addr_error_q;
  assign rd_word = hit ? {stor_addr_q[7:0], stor_addr_q} ^ 32'h5A5A5A5A : ~last_q;
  // Unselected storage shows a moving pattern
  always_ff @(posedge clk) begin
    last_q <= rd_word;
  end
endmodule // cerad_stor_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the register and arithmetic datapath
`timescale 1ns/1ns
module tb_top;
  typedef struct {int due; int kind; logic [63:0] exp; logic [63:0] mask;} cerad_note_t;
  // Stimulus and observed signals
  logic clk = 1'b0, reset = 1'b1, op_valid = 1'b0, src_storage = 1'b0, halfword = 1'b0;
  logic use_mem = 1'b0, dec_valid = 1'b0, dec_last = 1'b0, dec_zoned = 1'b0, mode_ext = 1'b0;
  logic [3:0] op_code = 4'h0, r1_sel = 4'h0, r2_sel = 4'h0;
  logic [5:0] shift_amt = 6'h0, access_len = 6'h1;
  logic [31:0] operand = 32'h0, v, w, result_q, rd_word;
  logic [63:0] fp_operand = 64'h0, d, fp_view_q;
  logic [23:0] addr_disp = 24'h0, ad, stor_addr_q;
  logic [7:0] dec_byte = 8'h0;
  logic [4:0] dec_len = 5'h1;
  logic [32:0] t;
  logic [1:0] e, cond_q;
  logic [3:0] sign_plus_q, sign_minus_q;
  logic op_done, spec_error, carry_q, main_sel_q, display_sel_q, addr_error_q;
  logic data_exception_q, dec_neg_q;
  logic [31:0] g[16];
  cerad_note_t q[$];
  cerad_note_t n;
  int err_count = 0, checks_done = 0, cyc = 0, i, k, seed = 32'h2C602B23;

  cerad_datapath dut (
    .clk, .reset, .op_valid, .op_code, .r1_sel, .r2_sel, .src_storage, .halfword, .shift_amt,
    .stor_operand(use_mem ? rd_word : operand), .fp_operand, .addr_disp, .access_len,
    .dec_valid, .dec_byte, .dec_last, .dec_zoned, .dec_len, .program_status_word_ext(mode_ext),
    .op_done, .spec_error, .result_q, .carry_q, .cond_q, .fp_view_q, .stor_addr_q, .main_sel_q,
    .display_sel_q, .addr_error_q, .data_exception_q, .dec_neg_q, .sign_plus_q, .sign_minus_q
  );
  cerad_stor_model u_stor (.clk, .stor_addr_q, .main_sel_q, .display_sel_q, .addr_error_q,
    .rd_word);

  // Clock and cycle count
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task check(input logic [63:0] seen, input logic [63:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task note(input int dl, kd, input logic [63:0] ex, input logic [63:0] m = '1);
    q.push_back('{cyc + dl, kd, ex & m, m});
  endtask

  task op(input logic [3:0] c, a, b, input logic [1:0] s, input logic h, input logic [31:0] x);
    @(negedge clk);
    op_valid = 1'b1;
    dec_valid = 1'b0;
    op_code = c;
    r1_sel = a;
    r2_sel = b;
    src_storage = |s;
    use_mem = s[1];
    halfword = h;
    operand = x;
    shift_amt = x[5:0];
    fp_operand = {x, x ^ 32'h5A5A5A5A};
  endtask

  task idle(input int c);
    repeat (c) begin
      @(negedge clk);
      op_valid = 1'b0;
      dec_valid = 1'b0;
    end
  endtask

  task ld(input logic [3:0] a, input logic [31:0] x);
    op(4'hA, a, 4'h0, 2'h1, 1'b0, x);
    g[a] = x;
    note(1, 0, 64'(x));
  endtask

  task add(input logic [3:0] a, b, input logic [1:0] s, input logic h, input logic [31:0] x);
    w = (s != 2'h0) ? x : g[b];
    if (h) w = {{16{w[15]}}, w[15:0]};
    op(4'h1, a, b, s, h, x);
    t = {1'b0, g[a]} + {1'b0, w};
    g[a] = t[31:0];
    note(1, 0, 64'(t[31:0]));
    note(1, 1, 64'({t[32], (t[31:0] == 32'h0) ? 2'h0 : {~t[31], t[31]}}));
  endtask

  task addr(input logic [23:0] a, input logic [5:0] l, input logic [2:0] ex, m);
    idle(1);
    addr_disp = a;
    access_len = l;
    note(1, 2, 64'({a, ex}), 64'({24'hFFFFFF, m}));
  endtask

  task dec(input logic [7:0] b, input logic l, z, input logic [1:0] ex, m);
    @(negedge clk);
    op_valid = 1'b0;
    dec_valid = 1'b1;
    dec_byte = b;
    dec_last = l;
    dec_zoned = z;
    dec_len = 5'({$random(seed)} % 16 + 1);
    note(1, 4, 64'(ex), 64'(m));
  endtask

  task wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Compare notes that have come due
  always @(negedge clk) begin
    #2;
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      case (n.kind)
        0: check(64'(result_q) & n.mask, n.exp);
        1: check(64'({carry_q, cond_q}) & n.mask, n.exp);
        2: check(64'({stor_addr_q, main_sel_q, display_sel_q, addr_error_q}) & n.mask, n.exp);
        3: check(64'({sign_plus_q, sign_minus_q}) & n.mask, n.exp);
        4: check(64'({data_exception_q, dec_neg_q}) & n.mask, n.exp);
        5: check(64'(spec_error) & n.mask, n.exp);
        6: check(fp_view_q & n.mask, n.exp);
        default: check(64'(op_done) & n.mask, n.exp);
      endcase
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (i = 0; i < 16; i++) ld(4'(i), $random(seed));
    ld(4'h0, 32'hFFFFFFFF);
    add(4'h0, 4'h0, 2'h1, 1'b0, 32'h1);
    for (i = 0; i < 10; i++) begin
      v = $random(seed);
      add(v[11:8], v[15:12], {1'b0, v[16]}, v[17], v);
    end
    // Single and pair shifts both ways
    for (k = 6; k < 10; k++) begin
      v = $random(seed);
      op(4'(k), 4'hA, 4'h0, 2'h0, 1'b0, v);
      d = {g[10], g[11]};
      if (k == 6) g[10] = g[10] << v[5:0];
      if (k == 7) g[10] = g[10] >> v[5:0];
      if (k == 8) d = d << v[5:0];
      if (k == 9) d = d >> v[5:0];
      if (k > 7) {g[10], g[11]} = d;
      add(4'hA, 4'h0, 2'h1, 1'b0, 32'h0);
      add(4'hB, 4'h0, 2'h1, 1'b0, 32'h0);
    end
    // Compare leaves the register alone
    v = $random(seed);
    op(4'h5, 4'h1, 4'h0, 2'h1, 1'b0, v);
    note(1, 1, (g[1] == v) ? 0 : (($signed(g[1]) < $signed(v)) ? 1 : 2), 64'h3);
    add(4'h1, 4'h0, 2'h1, 1'b0, 32'h0);
    // Subtract as add of inverse plus one
    v = $random(seed);
    op(4'h2, 4'h7, 4'h0, 2'h1, 1'b0, v);
    t = {1'b0, g[7]} + {1'b0, ~v} + 33'h1;
    g[7] = t[31:0];
    note(1, 0, 64'(t[31:0]));
    note(1, 1, 64'({t[32], (t[31:0] == 32'h0) ? 2'h0 : {~t[31], t[31]}}));
    // Wide product and divide in a pair
    v = $random(seed);
    op(4'h3, 4'h2, 4'h0, 2'h1, 1'b0, v);
    {g[2], g[3]} = $signed(g[3]) * $signed(v);
    add(4'h2, 4'h0, 2'h1, 1'b0, 32'h0);
    add(4'h3, 4'h0, 2'h1, 1'b0, 32'h0);
    v = $random(seed);
    ld(4'h4, 32'h0);
    ld(4'h5, {1'b0, v[30:0]});
    w = {16'h0, v[15:0]} | 32'h1;
    op(4'h4, 4'h4, 4'h0, 2'h1, 1'b0, w);
    note(2, 7, 64'h1);
    idle(4);
    g[4] = g[5] % w;
    g[5] = g[5] / w;
    add(4'h4, 4'h0, 2'h1, 1'b0, 32'h0);
    add(4'h5, 4'h0, 2'h1, 1'b0, 32'h0);
    // Refused register numbers, odd pair left intact
    op(4'h8, 4'h5, 4'h0, 2'h0, 1'b0, 32'h4);
    note(0, 5, 64'h1);
    op(4'hC, 4'h3, 4'h0, 2'h0, 1'b0, 32'h0);
    note(0, 5, 64'h1);
    op(4'hB, 4'h8, 4'h0, 2'h0, 1'b0, 32'h0);
    note(0, 5, 64'h1);
    add(4'h5, 4'h0, 2'h1, 1'b0, 32'h0);
    // Short load keeps the low word
    v = $random(seed);
    w = $random(seed);
    d = {v, v ^ 32'h5A5A5A5A};
    op(4'hC, 4'h6, 4'h0, 2'h0, 1'b0, v);
    note(0, 5, 64'h0);
    op(4'hB, 4'h6, 4'h0, 2'h0, 1'b0, w);
    note(1, 6, d);
    op(4'hB, 4'h6, 4'h0, 2'h0, 1'b0, 32'h0);
    note(1, 6, {w, d[31:0]});
    // Storage map edges and a model read
    addr(24'h000000, 6'h1, 3'h4, 3'h7);
    addr(24'h27FFFF, 6'h1, 3'h4, 3'h7);
    addr(24'h280000, 6'h8, 3'h2, 3'h7);
    addr(24'h2BFFF8, 6'h8, 3'h2, 3'h7);
    addr(24'h2BFFFF, 6'h2, 3'h1, 3'h5);
    addr(24'h4BFFF8, 6'h8, 3'h2, 3'h7);
    addr(24'h2C0000, 6'h1, 3'h1, 3'h7);
    addr(24'h680000, 6'h1, 3'h1, 3'h7);
    v = $random(seed);
    ad = v[23:0] & 24'h1FFFFC;
    addr(ad, 6'h4, 3'h4, 3'h7);
    op(4'hA, 4'hC, 4'h0, 2'h2, 1'b0, 32'h0);
    note(1, 0, 64'({ad[7:0], ad} ^ 32'h5A5A5A5A));
    // Generated signs in both modes
    for (i = 0; i < 2; i++) begin
      idle(1);
      mode_ext = i[0];
      note(1, 3, (i == 1) ? 64'hCD : 64'hAB);
    end
    // Every low nibble as the sign, then bad digit, good digits and zoned
    for (i = 0; i < 16; i++) begin
      e = (i < 10) ? 2'h2 : {1'b0, i == 11 || i == 13};
      dec(8'h50 | 8'(i), 1'b1, 1'b0, e, (i < 10) ? 2'h2 : 2'h3);
    end
    dec(8'hA3, 1'b0, 1'b0, 2'h2, 2'h2);
    dec(8'h12, 1'b0, 1'b0, 2'h0, 2'h2);
    dec(8'hD5, 1'b1, 1'b1, 2'h2, 2'h2);
    // Decimal operation refused when zoned, too long or empty
    for (i = 0; i < 4; i++) begin
      op(4'hD, 4'h0, 4'h0, 2'h0, 1'b0, 32'h0);
      dec_zoned = (i == 0);
      dec_len = (i == 1) ? 5'h11 : (i == 3) ? 5'h00 : 5'({$random(seed)} % 16 + 1);
      note(0, 5, 64'(i != 2));
    end
    idle(4);
    wrap_up();
  end
endmodule // tb_top
